//--- src/burst_sram_cycle.sv
/*
 * Flow-through burst SRAM core: cycle decode, byte-lane write decode,
 * two-bit burst counter, lane arrays and a read-beat stream FIFO.
 * Assumes the bus master drives strobes on the same rising clock edge;
 * sleep and output enable are asynchronous pins.
 */
// Operation
// - continue read burst at next address
// - continue write burst at next address
// - suspend read at current address, oe gated
// - suspend write at current address
// - read when no lane selected
// - global write writes all lanes
// - each low lane strobe writes its lane
// - any lane combination writes exactly those lanes
// - combined write term from global, enable, lanes
// - output enable asynchronous, masked on writes
// - processor strobe starts a read whenever the device is selected and not asleep
// - interleaved or linear two-bit burst order
`timescale 1ns/100ps

module stream_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = sram_cycle_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // filling side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // draining side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wr_ptr_r;
  logic [PW:0]      wr_ptr_nxt;
  logic [PW:0]      rd_ptr_r;
  logic [PW:0]      rd_ptr_nxt;
  logic             push;
  logic             pop;

  assign in_ready_out  = (wr_ptr_r - rd_ptr_r) != (PW+1)'(DEPTH);
  assign out_valid_out = wr_ptr_r != rd_ptr_r;
  assign out_data_out  = store[rd_ptr_r[PW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    wr_ptr_nxt = push ? wr_ptr_r + (PW+1)'(1) : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + (PW+1)'(1) : rd_ptr_r;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (push) begin
      store[wr_ptr_r[PW-1:0]] <= in_data_in;
    end
  end
endmodule : stream_fifo

module burst_sram_cycle #(
  parameter int LANES  = sram_cycle_pkg::LANES_WIDE,
  parameter int ADDR_W = sram_cycle_pkg::ADDR_W_WIDE,
  parameter int DW     = LANES * sram_cycle_pkg::LANE_W
) (
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_n_in,
  // address and selects
  input  wire logic [ADDR_W-1:0] address_in,
  input  wire logic              primary_chip_select_n_in,
  input  wire logic              depth_select_high_in,
  input  wire logic              depth_select_low_n_in,
  input  wire logic              sleep_request_in,
  // burst control
  input  wire logic              processor_address_strobe_n_in,
  input  wire logic              controller_address_strobe_n_in,
  input  wire logic              burst_advance_n_in,
  input  wire logic              burst_order_in,
  // write control
  input  wire logic              global_write_n_in,
  input  wire logic              byte_write_enable_n_in,
  input  wire logic [LANES-1:0]  lane_write_strobe_n_in,
  input  wire logic              output_enable_n_in,
  // data pins, split
  input  wire logic [DW-1:0]     dq_in,
  output logic      [DW-1:0]     dq_out,
  output logic                   dq_oe_out,
  // read-beat stream
  output logic      [DW-1:0]     rd_data_out,
  output logic                   rd_valid_out,
  input  wire logic              rd_ready_in,
  output logic                   rd_room_out
);
  localparam int LW = sram_cycle_pkg::LANE_W;

  logic                 sleep_s1_r;
  logic                 sleep_s2_r;
  logic [ADDR_W-1:0]    base_r;
  logic [ADDR_W-1:0]    base_nxt;
  logic [1:0]           cnt_r;
  logic [1:0]           cnt_nxt;
  sram_cycle_pkg::cycle_t cyc_r;
  sram_cycle_pkg::cycle_t cyc_nxt;
  logic                 selected;
  logic                 start_proc;
  logic                 start_ctrl;
  logic                 continuing;
  logic                 write_n;
  logic [LANES-1:0]     lane_we;
  logic [1:0]           low_addr;
  logic [ADDR_W-1:0]    acc_addr;
  logic                 wr_go;
  logic                 rd_go;

  // sleep is asynchronous to the bus clock
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      sleep_s1_r <= sleep_request_in;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  assign selected   = !primary_chip_select_n_in && depth_select_high_in
                      && !depth_select_low_n_in;
  assign start_proc = !processor_address_strobe_n_in && !primary_chip_select_n_in;
  assign start_ctrl = !controller_address_strobe_n_in;
  assign continuing = !sleep_s2_r && cyc_r.active && !start_proc && !start_ctrl;

  // combined write term and per-lane enables
  always_comb begin
    write_n = global_write_n_in
              && (byte_write_enable_n_in || &lane_write_strobe_n_in);
    if (!global_write_n_in) begin
      lane_we = '1;
    end else if (!byte_write_enable_n_in) begin
      lane_we = ~lane_write_strobe_n_in;
    end else begin
      lane_we = '0;
    end
  end

  // cycle decode and burst counter
  always_comb begin
    base_nxt = base_r;
    cnt_nxt  = cnt_r;
    cyc_nxt  = '{active: 1'b0, load: 1'b0, kind: sram_cycle_pkg::CYC_IDLE};
    if (sleep_s2_r) begin
      cyc_nxt.active = 1'b0;
    end else if (start_proc || start_ctrl) begin
      if (selected) begin
        base_nxt       = address_in;
        cnt_nxt        = sram_cycle_pkg::BURST_FIRST;
        cyc_nxt.active = 1'b1;
        cyc_nxt.load   = 1'b1;
        cyc_nxt.kind   = (start_proc || write_n) ? sram_cycle_pkg::CYC_READ
                                                 : sram_cycle_pkg::CYC_WRITE;
      end
    end else if (cyc_r.active) begin
      cyc_nxt.active = 1'b1;
      if (!burst_advance_n_in) begin
        cnt_nxt = cnt_r + sram_cycle_pkg::BURST_STEP;
      end
      cyc_nxt.kind = write_n ? sram_cycle_pkg::CYC_READ
                             : sram_cycle_pkg::CYC_WRITE;
    end
  end

  always_comb begin
    if (burst_order_in) begin
      low_addr = base_nxt[1:0] ^ cnt_nxt;
    end else begin
      low_addr = base_nxt[1:0] + cnt_nxt;
    end
    acc_addr = {base_nxt[ADDR_W-1:2], low_addr};
    wr_go    = cyc_nxt.kind == sram_cycle_pkg::CYC_WRITE;
    rd_go    = cyc_nxt.kind == sram_cycle_pkg::CYC_READ;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      base_r <= '0;
      cnt_r  <= '0;
      cyc_r  <= '{active: 1'b0, load: 1'b0, kind: sram_cycle_pkg::CYC_IDLE};
    end else begin
      base_r <= base_nxt;
      cnt_r  <= cnt_nxt;
      cyc_r  <= cyc_nxt;
    end
  end

  // one array per lane: eight data bits plus parity
  for (genvar ln = 0; ln < LANES; ln++) begin : g_lane
    logic [LW-1:0] mem [2**ADDR_W];
    always_ff @(posedge clock_in) begin
      if (wr_go && lane_we[ln]) begin
        mem[acc_addr] <= dq_in[ln*LW +: LW];
      end
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        dq_out[ln*LW +: LW] <= '0;
      end else if (rd_go) begin
        dq_out[ln*LW +: LW] <= mem[acc_addr];
      end
    end
  end

  // pins drive only on reads with output enable low
  assign dq_oe_out = (cyc_r.kind == sram_cycle_pkg::CYC_READ)
                     && !output_enable_n_in;

  stream_fifo #(
    .WIDTH (DW),
    .DEPTH (sram_cycle_pkg::FIFO_DEPTH)
  ) u_rd_fifo (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (cyc_r.kind == sram_cycle_pkg::CYC_READ),
    .in_ready_out  (rd_room_out),
    .in_data_in    (dq_out),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (rd_data_out)
  );

  a_read_drives_pins: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    continuing && write_n && !output_enable_n_in |=> dq_oe_out || output_enable_n_in)
    else $error("read cycle did not drive data pins");

  a_oe_masked_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    wr_go |=> !dq_oe_out)
    else $error("data pins driven during write cycle");

  a_suspend_holds_cnt: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    continuing && burst_advance_n_in |=> cnt_r == $past(cnt_r))
    else $error("suspend cycle moved burst counter");

  a_continue_adv_cnt: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    continuing && !burst_advance_n_in |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("continue cycle did not advance counter");

  a_global_all_lanes: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    continuing && !global_write_n_in |-> wr_go && (&lane_we))
    else $error("global write did not write all lanes");

  a_lane_exact_set: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    global_write_n_in && !byte_write_enable_n_in |-> lane_we == ~lane_write_strobe_n_in)
    else $error("lane enables differ from lane strobes");

  a_no_lane_reads: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    continuing && global_write_n_in && byte_write_enable_n_in |-> rd_go && lane_we == '0)
    else $error("cycle without lane writes not a read");

  a_proc_starts_read: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !sleep_s2_r && start_proc && selected |=> cyc_r.kind == sram_cycle_pkg::CYC_READ
    && cnt_r == 2'h0 && cyc_r.load)
    else $error("processor strobe did not start a read");

  a_linear_order: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    rd_go && !burst_order_in |-> acc_addr[1:0] == 2'(base_nxt[1:0] + cnt_nxt))
    else $error("linear burst address wrong");
endmodule : burst_sram_cycle

//--- include/sram_cycle_pkg.sv
/*
 * Shared constants and types for the burst SRAM cycle decoder.
 * Assumes the includer compiles this package before the design file.
 */
package sram_cycle_pkg;
  // lane layout: eight data bits plus one parity bit
  localparam int LANE_DATA_BITS = 8;
  localparam int LANE_PAR_BITS  = 1;
  localparam int LANE_W         = LANE_DATA_BITS + LANE_PAR_BITS;
  localparam int LANES_WIDE     = 4;
  localparam int LANES_NARROW   = 2;
  localparam int ADDR_W_WIDE    = 19;
  localparam int BURST_W        = 2;
  localparam int FIFO_DEPTH     = 16;
  localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;

  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_READ,
    CYC_WRITE
  } cycle_kind_t;

  // decoded cycle travelling from the decode to the array
  typedef struct packed {
    logic        active;
    logic        load;
    cycle_kind_t kind;
  } cycle_t;
endpackage : sram_cycle_pkg

//--- dv/bus_master_model.sv
/* processor-side bus master model for the burst SRAM decoder.
   assumes the bench calls cycle() once per clock, after reset. */
`timescale 1ns/100ps
module bus_master_model (
  // clock
  input  wire logic        clock_in,
  // pins toward the device: {ce1_n, proc_n, ctrl_n, adv_n, gw_n, bwe_n}
  output logic [5:0]       cmd_out,
  output logic [3:0]       lanes_n_out,
  output logic [18:0]      addr_out,
  output logic [35:0]      data_out,
  output logic             oe_n_out,
  // device reply
  input  wire logic [35:0] q_in,
  input  wire logic        q_oe_in
);
  logic oe_off = 1'b0;
  logic oe_on  = 1'b0;
  logic wr;
  initial begin
    cmd_out = 6'h37;
    lanes_n_out = 4'hf;
    addr_out = '0;
    data_out = '0;
    oe_n_out = 1'b1;
  end
  // drive one cycle at the edge, return what the prior cycle produced
  task automatic cycle(input logic [5:0] c, input logic [3:0] ln, input logic [18:0] a,
                       input logic [35:0] d, output logic [35:0] q, output logic qoe);
    @(posedge clock_in);
    wr = !c[1] || (!c[0] && ln != 4'hf);
    cmd_out <= c;
    lanes_n_out <= ln;
    addr_out <= a;
    // released data lines toggle rather than hold
    data_out <= wr ? d : ~data_out;
    // oe_on pulls enable low on a write already under way
    oe_n_out <= (wr | oe_off) & ~oe_on;
    #1;
    q = q_in;
    qoe = q_oe_in;
  endtask : cycle
endmodule : bus_master_model

//--- dv/sync_burst_sram_cycle_bench.sv
/* self-checking bench for the burst SRAM decoder, wide organisation.
   assumes the bus master model and the design package are compiled. */
`timescale 1ns/100ps
module sync_burst_sram_cycle_bench;
  localparam logic [5:0] WR_START = 6'h15;
  localparam logic [5:0] RD_START = 6'h17;
  localparam logic [5:0] LN_START = 6'h16;
  localparam logic [5:0] RD_CONT  = 6'h1b;
  localparam logic [5:0] WR_CONT  = 6'h19;
  localparam logic [5:0] RD_SUSP  = 6'h1f;
  localparam logic [5:0] WR_SUSP  = 6'h1d;
  localparam logic [5:0] PROC_RD  = 6'h0c;
  localparam logic [5:0] DESEL    = 6'h37;
  localparam logic [5:0] IDLE     = 6'h3f;
  logic        clock_in = 1'b0;
  logic        sleep    = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        order    = 1'b1;
  logic        rd_ready = 1'b1;
  logic [35:0] q;
  logic        qoe;
  logic [35:0] mem [4];
  int          num_errors = 0;
  int          tests_run = 0;
  wire  [5:0]  cmd;
  wire  [3:0]  lanes_n;
  wire  [18:0] addr;
  wire  [35:0] wdata;
  wire  [35:0] rdata;
  wire  [35:0] rd_q;
  wire         oe_n;
  wire         dq_oe;
  wire         rd_valid;
  wire         rd_room;
  always #20 clock_in = ~clock_in;
  bus_master_model i_host (.clock_in(clock_in), .cmd_out(cmd), .lanes_n_out(lanes_n),
    .addr_out(addr), .data_out(wdata), .oe_n_out(oe_n), .q_in(rdata), .q_oe_in(dq_oe));
  burst_sram_cycle i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .address_in(addr),
    .primary_chip_select_n_in(cmd[5]), .depth_select_high_in(1'b1),
    .depth_select_low_n_in(1'b0), .sleep_request_in(sleep),
    .processor_address_strobe_n_in(cmd[4]), .controller_address_strobe_n_in(cmd[3]),
    .burst_advance_n_in(cmd[2]), .burst_order_in(order), .global_write_n_in(cmd[1]),
    .byte_write_enable_n_in(cmd[0]), .lane_write_strobe_n_in(lanes_n),
    .output_enable_n_in(oe_n), .dq_in(wdata), .dq_out(rdata), .dq_oe_out(dq_oe),
    .rd_data_out(rd_q), .rd_valid_out(rd_valid), .rd_ready_in(rd_ready), .rd_room_out(rd_room));
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask : check
  task automatic cyc(input logic [5:0] c, input logic [18:0] a, input logic [35:0] d);
    i_host.cycle(c, 4'hf, a, d, q, qoe);
  endtask : cyc
  task automatic write_burst();
    for (int a = 0; a < 4; a++) begin
      mem[a] = 36'ha5a5a5a50 + 36'(a);
      cyc(WR_START, 19'(a), mem[a]);
    end
    cyc(WR_START, '0, 36'h123456789);
    check(36'(qoe), 36'h0);
    cyc(WR_CONT, '0, 36'h2468ace02);
    i_host.oe_on = 1'b1;
    cyc(WR_SUSP, '0, 36'h13579bdf1);
    check(36'(qoe), 36'h0);
    i_host.oe_on = 1'b0;
    cyc(DESEL, '0, '0);
    mem[0] = 36'h123456789;
    mem[1] = 36'h13579bdf1;
  endtask : write_burst
  task automatic read_burst(input logic [1:0] base, input logic ord);
    logic [1:0] n;
    @(posedge clock_in);
    order <= ord;
    cyc(RD_START, 19'(base), '0);
    cyc(RD_SUSP, '0, '0);
    check(q, mem[base]);
    check(36'(qoe), 36'h1);
    cyc(RD_CONT, '0, '0);
    check(q, mem[base]);
    for (int k = 1; k < 3; k++) begin
      cyc(k == 2 ? DESEL : RD_CONT, '0, '0);
      n = ord ? base ^ 2'(k) : base + 2'(k);
      check(q, mem[n]);
    end
  endtask : read_burst
  task automatic lane_writes();
    logic [35:0] d;
    for (int m = 0; m < 16; m++) begin
      d = {4{~4'(m), 1'b1, 4'(m)}};
      i_host.cycle(LN_START, 4'(m), 19'h2, d, q, qoe);
      for (int i = 0; i < 4; i++)
        if (!m[i])
          mem[2][9*i +: 9] = d[9*i +: 9];
      cyc(RD_START, 19'h2, '0);
      cyc(DESEL, '0, '0);
      check(q, mem[2]);
    end
  endtask : lane_writes
  task automatic proc_read();
    cyc(PROC_RD, 19'h3, ~mem[3]);
    cyc(DESEL, '0, '0);
    check(q, mem[3]);
    cyc(RD_START, 19'h3, '0);
    cyc(DESEL, '0, '0);
    check(q, mem[3]);
    i_host.oe_off = 1'b1;
    cyc(RD_START, 19'h3, '0);
    cyc(DESEL, '0, '0);
    check(36'(qoe), 36'h0);
    i_host.oe_off = 1'b0;
  endtask : proc_read
  task automatic fifo_fill();
    int n;
    n = 0;
    @(posedge clock_in);
    rd_ready <= 1'b0;
    cyc(RD_START, '0, '0);
    repeat (20) cyc(RD_SUSP, '0, '0);
    repeat (4) cyc(DESEL, '0, '0);
    check(36'(rd_room), 36'h0);
    @(posedge clock_in);
    rd_ready <= 1'b1;
    repeat (40) begin
      #1;
      if (rd_valid === 1'b1) begin
        // head is the last beat of the previous burst, then the held reads
        check(rd_q, (n == 0) ? mem[3] : mem[0]);
        n++;
      end
      @(posedge clock_in);
    end
    check(36'(n), 36'h10);
  endtask : fifo_fill
  task automatic reset_values();
    #1;
    check(rdata, '0);
    check(36'(dq_oe), 36'h0);
    check(36'(rd_valid), 36'h0);
    check(36'(rd_room), 36'h1);
  endtask : reset_values
  task automatic sleep_test();
    @(posedge clock_in);
    sleep <= 1'b1;
    repeat (3) cyc(IDLE, '0, '0);
    cyc(WR_START, '0, ~mem[0]);
    cyc(IDLE, '0, '0);
    @(posedge clock_in);
    sleep <= 1'b0;
    repeat (3) cyc(IDLE, '0, '0);
    cyc(RD_START, '0, '0);
    cyc(DESEL, '0, '0);
    check(q, mem[0]);
  endtask : sleep_test
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (4) @(posedge clock_in);
    reset_values();
    @(posedge clock_in);
    rst_n_in <= 1'b1;
    write_burst();
    read_burst(2'h0, 1'b1);
    lane_writes();
    proc_read();
    sleep_test();
    read_burst(2'h1, 1'b1);
    read_burst(2'h1, 1'b0);
    fifo_fill();
    wrap_up();
  end
endmodule : sync_burst_sram_cycle_bench
